// ### core/cdrb_bank.sv
// register bank of the voice coil driver: current code, faults, mode, resonance
// What this block does
// - The drive current is the code times 0.1 mA, zero at code zero and 102.3 mA at all ones.
// - All fault flags clear on the move from standby to active.
// - A thermal trip forces standby and blocks active until the die cools and the thermal flag clears.
// - Status bits 0 to 4 report overcurrent, undervoltage, coil open, coil short and thermal, bits 7:5 zero.
// - Mode bit 0 selects settling over two resonance periods at 0 and one period at 1.
// - Mode bit 1 selects PWM drive at 0 and linear drive at 1.
// - Mode bits 4:2 select 0.5, 1, 2, 4.8, 6.0 or 4 MHz for codes 0, 1, 3, 5, 6, 7; codes 2 and 4 do not exist.
// - The resonance setting resets to 0x83.
// - Writing one to the soft reset bit restores all defaults except the register pointer, enters standby and the bit reads back zero.
// - The register pointer advances by one after every data byte written or read.
`timescale 1ns/10ps
module cdrb_bank (
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    input  wire cdrb_pkg::cdrb_bus_type bus_i,
    output logic [7:0]                 rd_data_o,
    output logic                       rd_valid_o,
    input  wire logic                  wake_i,
    input  wire logic                  sleep_i,
    input  wire logic [4:0]            fault_detect_i,
    output logic                       active_o,
    output logic [9:0]                 coil_current_code_o,
    output logic [16:0]                coil_current_ua_o,
    output logic                       ring_enable_o,
    output logic [1:0]                 settle_periods_o,
    output logic                       linear_mode_o,
    output logic [12:0]                switching_rate_khz_o,
    output logic                       switching_rate_valid_o,
    output logic [7:0]                 resonance_setting_o
);
    cdrb_pkg::cdrb_state_type state;
    cdrb_pkg::cdrb_state_type next_state;
    logic [4:0]               flags;
    logic [4:0]               flag_clear;
    logic                     soft_reset;
    logic                     go_active;
    logic                     thermal_trip;
    logic [7:0]               read_value;
    logic [2:0]               rate_code;
    logic [13:0]              rate_entry;

    ////////////////////////////////////////////////////////////////////////////
    // switching rate lookup
    function automatic logic [13:0] cdrb_rate_lookup(input logic [2:0] code);
        logic [13:0] result;
        result = 14'h0000;
        case (code)
            cdrb_pkg::RATE_CODE_0M5: result = {1'b1, cdrb_pkg::RATE_KHZ_0M5};
            cdrb_pkg::RATE_CODE_1M:  result = {1'b1, cdrb_pkg::RATE_KHZ_1M};
            cdrb_pkg::RATE_CODE_2M:  result = {1'b1, cdrb_pkg::RATE_KHZ_2M};
            cdrb_pkg::RATE_CODE_4M8: result = {1'b1, cdrb_pkg::RATE_KHZ_4M8};
            cdrb_pkg::RATE_CODE_6M:  result = {1'b1, cdrb_pkg::RATE_KHZ_6M};
            cdrb_pkg::RATE_CODE_4M:  result = {1'b1, cdrb_pkg::RATE_KHZ_4M};
            default:                 result = 14'h0000; // missing codes drive nothing
        endcase
        return result;
    endfunction : cdrb_rate_lookup

    ////////////////////////////////////////////////////////////////////////////
    // power state events
    assign soft_reset   = bus_i.wr_en && !bus_i.ptr_load
                          && (state.pointer == cdrb_pkg::REG_CONTROL)
                          && bus_i.data[cdrb_pkg::CTRL_SOFT_RESET_BIT];
    assign thermal_trip = flags[cdrb_pkg::FLAG_THERMAL] || fault_detect_i[cdrb_pkg::FLAG_THERMAL];
    assign go_active    = (state.power == cdrb_pkg::CDRB_STANDBY) && wake_i && !soft_reset
                          && !thermal_trip;

    // flag clear terms: wake, soft reset, and a cooled die while in standby
    always_comb begin
        flag_clear = {5{go_active || soft_reset}};
        if ((state.power == cdrb_pkg::CDRB_STANDBY)
            && !fault_detect_i[cdrb_pkg::FLAG_THERMAL]) begin
            flag_clear[cdrb_pkg::FLAG_THERMAL] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky fault flags, one cell for each of status bits 0 to 4
    genvar gi;
    generate
        for (gi = 0; gi < cdrb_pkg::FLAG_COUNT; gi++) begin : g_flag
            cdrb_fault_flag u_flag (
                .core_clk_i (core_clk_i),
                .arst_n_i   (arst_n_i),
                .set_i      (fault_detect_i[gi]),
                .clear_i    (flag_clear[gi]),
                .flag_o     (flags[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer, unused bits and unmapped offsets read zero
    always_comb begin
        read_value = 8'h00;
        if (state.pointer == cdrb_pkg::REG_CONTROL) begin
            read_value[cdrb_pkg::CTRL_RING_EN_BIT] = state.ring_enable;
        end else if (state.pointer == cdrb_pkg::REG_CURRENT_HIGH) begin
            read_value = {6'h00, state.current_upper};
        end else if (state.pointer == cdrb_pkg::REG_CURRENT_LOW) begin
            read_value = state.current_lower;
        end else if (state.pointer == cdrb_pkg::REG_FAULT_STATUS) begin
            read_value = {3'h0, flags};
        end else if (state.pointer == cdrb_pkg::REG_DRIVE_MODE) begin
            read_value = {3'h0, state.mode};
        end else if (state.pointer == cdrb_pkg::REG_RESONANCE) begin
            read_value = state.resonance;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state of the bank
    always_comb begin
        next_state          = state;
        next_state.rd_valid = 1'b0;
        // pointer handling and byte transfers
        if (bus_i.ptr_load) begin
            next_state.pointer = bus_i.data;
        end else if (bus_i.wr_en) begin
            next_state.pointer = state.pointer + 8'h01;
            if (state.pointer == cdrb_pkg::REG_CONTROL) begin
                next_state.ring_enable = bus_i.data[cdrb_pkg::CTRL_RING_EN_BIT];
            end else if (state.pointer == cdrb_pkg::REG_CURRENT_HIGH) begin
                next_state.current_upper = bus_i.data[cdrb_pkg::CUR_UPPER_MSB:0];
            end else if (state.pointer == cdrb_pkg::REG_CURRENT_LOW) begin
                next_state.current_lower = bus_i.data;
                next_state.applied_code  = {state.current_upper, bus_i.data};
            end else if (state.pointer == cdrb_pkg::REG_DRIVE_MODE) begin
                next_state.mode = bus_i.data[cdrb_pkg::MODE_RATE_MSB:0];
            end else if (state.pointer == cdrb_pkg::REG_RESONANCE) begin
                next_state.resonance = bus_i.data;
            end
        end else if (bus_i.rd_en) begin
            next_state.pointer  = state.pointer + 8'h01;
            next_state.rd_data  = read_value;
            next_state.rd_valid = 1'b1;
        end
        // drive current tracks the applied code
        next_state.current_ua = 17'(next_state.applied_code) * cdrb_pkg::CURRENT_STEP_UA;
        // power state machine
        case (state.power)
            cdrb_pkg::CDRB_STANDBY: begin
                if (go_active) begin
                    next_state.power = cdrb_pkg::CDRB_ACTIVE;
                end
            end
            cdrb_pkg::CDRB_ACTIVE: begin
                if (thermal_trip || sleep_i) begin
                    next_state.power = cdrb_pkg::CDRB_STANDBY;
                end
            end
            default: begin
                next_state.power = cdrb_pkg::CDRB_STANDBY;
            end
        endcase
        // soft reset restores defaults, keeps pointer advance and read answer
        if (soft_reset) begin
            next_state.ring_enable   = cdrb_pkg::CONTROL_RESET[cdrb_pkg::CTRL_RING_EN_BIT];
            next_state.current_upper = cdrb_pkg::CURRENT_HIGH_RESET[cdrb_pkg::CUR_UPPER_MSB:0];
            next_state.current_lower = cdrb_pkg::CURRENT_LOW_RESET;
            next_state.applied_code  = {cdrb_pkg::CURRENT_HIGH_RESET[cdrb_pkg::CUR_UPPER_MSB:0],
                                        cdrb_pkg::CURRENT_LOW_RESET};
            next_state.current_ua    = 17'h00000;
            next_state.mode          = cdrb_pkg::DRIVE_MODE_RESET[cdrb_pkg::MODE_RATE_MSB:0];
            next_state.resonance     = cdrb_pkg::RESONANCE_RESET;
            next_state.power         = cdrb_pkg::CDRB_STANDBY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state.ring_enable   <= cdrb_pkg::CONTROL_RESET[cdrb_pkg::CTRL_RING_EN_BIT];
            state.current_upper <= cdrb_pkg::CURRENT_HIGH_RESET[cdrb_pkg::CUR_UPPER_MSB:0];
            state.current_lower <= cdrb_pkg::CURRENT_LOW_RESET;
            state.mode          <= cdrb_pkg::DRIVE_MODE_RESET[cdrb_pkg::MODE_RATE_MSB:0];
            state.resonance     <= cdrb_pkg::RESONANCE_RESET;
            state.applied_code  <= 10'h000;
            state.current_ua    <= 17'h00000;
            state.pointer       <= cdrb_pkg::POINTER_RESET;
            state.rd_data       <= 8'h00;
            state.rd_valid      <= 1'b0;
            state.power         <= cdrb_pkg::CDRB_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs from the registered state
    assign rate_code              = state.mode[cdrb_pkg::MODE_RATE_MSB:cdrb_pkg::MODE_RATE_LSB];
    assign rd_data_o              = state.rd_data;
    assign rd_valid_o             = state.rd_valid;
    assign active_o               = (state.power == cdrb_pkg::CDRB_ACTIVE);
    assign coil_current_code_o    = state.applied_code;
    assign coil_current_ua_o      = state.current_ua;
    assign ring_enable_o          = state.ring_enable;
    assign settle_periods_o       = state.mode[cdrb_pkg::MODE_SETTLE_BIT]
                                    ? cdrb_pkg::SETTLE_FAST
                                    : cdrb_pkg::SETTLE_SLOW;
    assign linear_mode_o          = state.mode[cdrb_pkg::MODE_OUTPUT_BIT];
    assign rate_entry             = cdrb_rate_lookup(rate_code);
    assign switching_rate_khz_o   = rate_entry[12:0];
    assign switching_rate_valid_o = rate_entry[13];
    assign resonance_setting_o    = state.resonance;

endmodule : cdrb_bank

// ### core/cdrb_pkg.sv
// constants, field layouts and carrier types of the coil driver register bank
package cdrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses on the serial port)
    localparam logic [7:0] REG_CONTROL      = 8'h02;
    localparam logic [7:0] REG_CURRENT_HIGH = 8'h03;
    localparam logic [7:0] REG_CURRENT_LOW  = 8'h04;
    localparam logic [7:0] REG_FAULT_STATUS = 8'h05;
    localparam logic [7:0] REG_DRIVE_MODE   = 8'h06;
    localparam logic [7:0] REG_RESONANCE    = 8'h07;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CONTROL_RESET      = 8'h02;
    localparam logic [7:0] CURRENT_HIGH_RESET = 8'h00;
    localparam logic [7:0] CURRENT_LOW_RESET  = 8'h00;
    localparam logic [7:0] DRIVE_MODE_RESET   = 8'h00;
    localparam logic [7:0] RESONANCE_RESET    = 8'h83;
    localparam logic [7:0] POINTER_RESET      = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_RING_EN_BIT    = 1;
    localparam int CUR_UPPER_MSB       = 1;
    localparam int MODE_SETTLE_BIT     = 0;
    localparam int MODE_OUTPUT_BIT     = 1;
    localparam int MODE_RATE_LSB       = 2;
    localparam int MODE_RATE_MSB       = 4;
    localparam int FLAG_OVERCURRENT    = 0;
    localparam int FLAG_UNDERVOLTAGE   = 1;
    localparam int FLAG_COIL_OPEN      = 2;
    localparam int FLAG_COIL_SHORT     = 3;
    localparam int FLAG_THERMAL        = 4;
    localparam int FLAG_COUNT          = 5;

    ////////////////////////////////////////////////////////////////////////////
    // drive scaling: one code step is 0.1 mA, expressed in microamps
    localparam logic [16:0] CURRENT_STEP_UA = 17'h00064;
    // settling in resonance periods
    localparam logic [1:0]  SETTLE_SLOW     = 2'h2;
    localparam logic [1:0]  SETTLE_FAST     = 2'h1;
    // switching rate codes and rates in kHz
    localparam logic [2:0]  RATE_CODE_0M5   = 3'h0;
    localparam logic [2:0]  RATE_CODE_1M    = 3'h1;
    localparam logic [2:0]  RATE_CODE_2M    = 3'h3;
    localparam logic [2:0]  RATE_CODE_4M8   = 3'h5;
    localparam logic [2:0]  RATE_CODE_6M    = 3'h6;
    localparam logic [2:0]  RATE_CODE_4M    = 3'h7;
    localparam logic [12:0] RATE_KHZ_0M5    = 13'h01F4;
    localparam logic [12:0] RATE_KHZ_1M     = 13'h03E8;
    localparam logic [12:0] RATE_KHZ_2M     = 13'h07D0;
    localparam logic [12:0] RATE_KHZ_4M8    = 13'h12C0;
    localparam logic [12:0] RATE_KHZ_6M     = 13'h1770;
    localparam logic [12:0] RATE_KHZ_4M     = 13'h0FA0;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [0:0] {
        CDRB_STANDBY = 1'b0,
        CDRB_ACTIVE  = 1'b1
    } cdrb_power_type;

    // byte-level requests from the serial framer
    typedef struct packed {
        logic       ptr_load;
        logic       wr_en;
        logic       rd_en;
        logic [7:0] data;
    } cdrb_bus_type;

    // everything the bank holds apart from the fault flags, which sit in the flag cells
    typedef struct packed {
        logic           ring_enable;
        logic [1:0]     current_upper;
        logic [7:0]     current_lower;
        logic [4:0]     mode;
        logic [7:0]     resonance;
        logic [9:0]     applied_code;
        logic [16:0]    current_ua;
        logic [7:0]     pointer;
        logic [7:0]     rd_data;
        logic           rd_valid;
        cdrb_power_type power;
    } cdrb_state_type;

    typedef struct packed {
        logic flag;
    } cdrb_flag_state_type;

endpackage : cdrb_pkg

// ### core/cdrb_fault_flag.sv
// one sticky fault flag: set by its detector, set wins over clear
`timescale 1ns/10ps
module cdrb_fault_flag (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic set_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    cdrb_pkg::cdrb_flag_state_type state;
    cdrb_pkg::cdrb_flag_state_type next_state;

    // next flag value, set has priority
    always_comb begin
        next_state = state;
        if (set_i) begin
            next_state.flag = 1'b1;
        end else if (clear_i) begin
            next_state.flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag_o = state.flag;

endmodule : cdrb_fault_flag

// ### test/cdrb_bank_sva.sv
// port assertions of the coil driver register bank
`timescale 1ns/10ps
module cdrb_bank_sva (
    input  wire logic                   core_clk_i,
    input  wire logic                   arst_n_i,
    input  wire cdrb_pkg::cdrb_bus_type bus_i,
    input  wire logic [7:0]             rd_data_o,
    input  wire logic                   rd_valid_o,
    input  wire logic                   wake_i,
    input  wire logic [4:0]             fault_detect_i,
    input  wire logic                   active_o,
    input  wire logic [9:0]             coil_current_code_o,
    input  wire logic [16:0]            coil_current_ua_o,
    input  wire logic [1:0]             settle_periods_o,
    input  wire logic                   linear_mode_o,
    input  wire logic [12:0]            switching_rate_khz_o,
    input  wire logic                   switching_rate_valid_o,
    input  wire logic [7:0]             resonance_setting_o
);
    logic       wr;
    logic       rd;
    logic [7:0] ptr;
    // taken write and read, with the bus priority
    assign wr = bus_i.wr_en && !bus_i.ptr_load;
    assign rd = bus_i.rd_en && !bus_i.wr_en && !bus_i.ptr_load;
    // shadow of the auto-incrementing pointer
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr <= 8'h00;
        end else if (bus_i.ptr_load) begin
            ptr <= bus_i.data;
        end else if (wr || rd) begin
            ptr <= ptr + 8'h01;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    status_read_a: assert property (rd && ptr == 8'h05 |=> rd_valid_o && rd_data_o[7:5] == 3'h0)
        else $error("status read shows upper bits");
    ctrl_read_a: assert property (rd && ptr == 8'h02 |=> rd_data_o[7:2] == 6'h00 && !rd_data_o[0])
        else $error("control read wrong");
    res_read_a: assert property (rd && ptr == 8'h07 |=> rd_data_o == resonance_setting_o)
        else $error("resonance read mismatch");
    high_hold_a: assert property (wr && ptr == 8'h03 |=> $stable(coil_current_code_o))
        else $error("high write moved current");
    low_apply_a: assert property (wr && ptr == 8'h04 |=> coil_current_code_o[7:0] == $past(bus_i.data))
        else $error("low write not applied");
    ua_scale_a: assert property (coil_current_ua_o == 17'(coil_current_code_o) * 17'h00064)
        else $error("current scaling wrong");
    mode_map_a: assert property (wr && ptr == 8'h06 |=> linear_mode_o == $past(bus_i.data[1])
        && settle_periods_o == ($past(bus_i.data[0]) ? 2'h1 : 2'h2))
        else $error("mode decode wrong");
    rate_gap_a: assert property (switching_rate_valid_o == (switching_rate_khz_o != 13'h0000))
        else $error("rate valid disagrees");
    thermal_drop_a: assert property (active_o && fault_detect_i[4] |=> !active_o)
        else $error("active held under thermal trip");
    wake_guard_a: assert property ($rose(active_o) |-> $past(wake_i) && !$past(fault_detect_i[4]))
        else $error("active without clean wake");
    soft_reset_a: assert property (wr && ptr == 8'h02 && bus_i.data[0] |=> !active_o
        && coil_current_code_o == 10'h000 && resonance_setting_o == 8'h83)
        else $error("soft reset incomplete");
endmodule : cdrb_bank_sva
bind cdrb_bank cdrb_bank_sva i_cdrb_bank_sva (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .bus_i(bus_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wake_i(wake_i),
    .fault_detect_i(fault_detect_i), .active_o(active_o),
    .coil_current_code_o(coil_current_code_o), .coil_current_ua_o(coil_current_ua_o),
    .settle_periods_o(settle_periods_o), .linear_mode_o(linear_mode_o),
    .switching_rate_khz_o(switching_rate_khz_o),
    .switching_rate_valid_o(switching_rate_valid_o), .resonance_setting_o(resonance_setting_o));

// ### test/cdrb_host_model.sv
// host side model: issues byte requests to the register bank
`timescale 1ns/10ps
module cdrb_host_model (
    input  wire logic             core_clk_i,
    output cdrb_pkg::cdrb_bus_type bus_o
);
    initial bus_o = '0;
    // one request {ptr_load, wr_en, rd_en} launched off the falling edge
    task automatic xfer(input logic [2:0] k, input logic [7:0] d);
        @(negedge core_clk_i);
        bus_o = {k, d};
    endtask : xfer
    // release: strobes low, stale data inverted
    task automatic idle();
        @(negedge core_clk_i);
        bus_o = {3'h0, ~bus_o.data};
    endtask : idle
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        xfer(3'h4, a);
        xfer(3'h2, d);
        idle();
    endtask : write_byte
    // both current bytes, high then low, in one burst
    task automatic set_current(input logic [9:0] c);
        xfer(3'h4, 8'h03);
        xfer(3'h2, {6'h00, c[9:8]});
        xfer(3'h2, c[7:0]);
        idle();
    endtask : set_current
    task automatic read_seq(input logic [7:0] a, input int n);
        xfer(3'h4, a);
        repeat (n) xfer(3'h1, ~a);
        idle();
    endtask : read_seq
    // resonance setting from a frequency in hertz, rounded
    function automatic logic [7:0] resonance_code(input int hz);
        return 8'(383 - (19200 + hz / 2) / hz);
    endfunction : resonance_code
endmodule : cdrb_host_model

// ### test/cdrb_bank_tb_top.sv
// self-checking bench of the coil driver register bank
`timescale 1ns/10ps
module cdrb_bank_tb_top;
    logic                   core_clk_i = 1'b0;
    logic                   arst_n_i = 1'b0;
    logic                   wake_i = 1'b0;
    logic                   sleep_i = 1'b0;
    logic [4:0]             fault_detect_i = 5'h00;
    cdrb_pkg::cdrb_bus_type bus;
    logic [7:0]             rd_data_o, resonance_setting_o, b, m;
    logic                   rd_valid_o, active_o, ring_enable_o, linear_mode_o, rate_ok;
    logic [9:0]             code, c, p;
    logic [16:0]            ua;
    logic [1:0]             settle;
    logic [12:0]            khz;
    logic [7:0]             exp_q[$];
    int                     fails = 0;
    int                     n_checks = 0;
    logic [12:0] khz_tab [8] = '{cdrb_pkg::RATE_KHZ_0M5, cdrb_pkg::RATE_KHZ_1M, 13'h0000,
        cdrb_pkg::RATE_KHZ_2M, 13'h0000, cdrb_pkg::RATE_KHZ_4M8, cdrb_pkg::RATE_KHZ_6M,
        cdrb_pkg::RATE_KHZ_4M};
    cdrb_host_model i_cdrb_host_model (.core_clk_i(core_clk_i), .bus_o(bus));
    cdrb_bank i_cdrb_bank (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .bus_i(bus),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wake_i(wake_i), .sleep_i(sleep_i),
        .fault_detect_i(fault_detect_i), .active_o(active_o), .coil_current_code_o(code),
        .coil_current_ua_o(ua), .ring_enable_o(ring_enable_o), .settle_periods_o(settle),
        .linear_mode_o(linear_mode_o), .switching_rate_khz_o(khz),
        .switching_rate_valid_o(rate_ok), .resonance_setting_o(resonance_setting_o));
    always #25 core_clk_i = ~core_clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // one-cycle wake input pulse
    task automatic pulse_wake();
        @(negedge core_clk_i) wake_i = 1'b1;
        @(negedge core_clk_i) wake_i = 1'b0;
    endtask : pulse_wake
    ////////////////////////////////////////////////////////////////////////
    // read results against the oldest note
    always @(negedge core_clk_i) begin
        if (rd_valid_o !== 1'b0) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("MISMATCH t=%0t unexpected read data", $time);
            end else begin
                chk(rd_data_o, exp_q.pop_front());
            end
        end
    end
    // watchdog
    initial begin
        #(3000 * 50);
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h0D60));
        repeat (12) @(posedge core_clk_i);
        @(negedge core_clk_i) arst_n_i = 1'b1;
        // defaults through one auto-incrementing burst
        exp_q = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h83};
        i_cdrb_host_model.read_seq(8'h02, 6);
        chk(settle, 2'h2);
        chk(khz, cdrb_pkg::RATE_KHZ_0M5);
        // high byte alone holds, the pair applies; ends at full scale
        p = 10'h000;
        for (int k = 0; k < 3; k++) begin
            c = (k == 2) ? 10'h3FF : 10'($urandom);
            b = 8'($urandom);
            i_cdrb_host_model.write_byte(8'h03, {b[7:2], c[9:8]});
            chk(code, p);
            exp_q.push_back({6'h00, c[9:8]});
            i_cdrb_host_model.read_seq(8'h03, 1);
            i_cdrb_host_model.set_current(c);
            chk(code, c);
            chk(ua, 32'(c) * 32'h64);
            p = c;
        end
        // every available rate code, random upper and low mode bits
        for (int r = 0; r < 8; r++) begin
            if (r != 2 && r != 4) begin
                m = 8'($urandom);
                m[4:2] = 3'(r);
                i_cdrb_host_model.write_byte(8'h06, m);
                chk(settle, m[0] ? 2'h1 : 2'h2);
                chk(linear_mode_o, m[1]);
                chk(khz, khz_tab[r]);
                chk(rate_ok, 1'b1);
                exp_q.push_back({3'h0, m[4:0]});
                i_cdrb_host_model.read_seq(8'h06, 1);
            end
        end
        i_cdrb_host_model.write_byte(8'h07, i_cdrb_host_model.resonance_code(100));
        chk(resonance_setting_o, 8'hBF);
        // sticky flags, status is not writable, wake clears them
        b = 8'($urandom) & 8'h0F | 8'h01;
        @(negedge core_clk_i) fault_detect_i = b[4:0];
        @(negedge core_clk_i) fault_detect_i = 5'h00;
        i_cdrb_host_model.write_byte(8'h05, 8'hFF);
        exp_q.push_back(b);
        i_cdrb_host_model.read_seq(8'h05, 1);
        pulse_wake();
        chk(active_o, 1'b1);
        exp_q.push_back(8'h00);
        i_cdrb_host_model.read_seq(8'h05, 1);
        // thermal trip forces standby and blocks wake while hot
        @(negedge core_clk_i) fault_detect_i = 5'h10;
        pulse_wake();
        chk(active_o, 1'b0);
        exp_q.push_back(8'h10);
        i_cdrb_host_model.read_seq(8'h05, 1);
        @(negedge core_clk_i) fault_detect_i = 5'h00;
        pulse_wake();
        chk(active_o, 1'b1);
        // flag sticky while active, kept through sleep, cleared on the next wake
        @(negedge core_clk_i) fault_detect_i = 5'h01;
        @(negedge core_clk_i) fault_detect_i = 5'h00;
        @(negedge core_clk_i) sleep_i = 1'b1;
        @(negedge core_clk_i) sleep_i = 1'b0;
        chk(active_o, 1'b0);
        exp_q.push_back(8'h01);
        i_cdrb_host_model.read_seq(8'h05, 1);
        pulse_wake();
        chk(active_o, 1'b1);
        exp_q.push_back(8'h00);
        i_cdrb_host_model.read_seq(8'h05, 1);
        // ring enable, then soft reset from active
        i_cdrb_host_model.write_byte(8'h02, 8'h00);
        chk(ring_enable_o, 1'b0);
        @(negedge core_clk_i) fault_detect_i = 5'h08;
        @(negedge core_clk_i) fault_detect_i = 5'h00;
        i_cdrb_host_model.write_byte(8'h02, 8'hFD);
        chk({active_o, ring_enable_o, code, resonance_setting_o}, {2'h1, 10'h000, 8'h83});
        exp_q = '{8'h02, 8'h00, 8'h00};
        i_cdrb_host_model.read_seq(8'h02, 1);
        i_cdrb_host_model.read_seq(8'h20, 1);
        i_cdrb_host_model.read_seq(8'h05, 1);
        // let the watcher take the last read before counting leftovers
        @(posedge core_clk_i);
        chk(exp_q.size(), 0);
        print_verdict();
    end
endmodule : cdrb_bank_tb_top
